// ===== inc/adcfc_pkg.sv
// constants for the converter control and result fifo block
`default_nettype none
package adcfc_pkg;
	localparam int unsigned CLK_FREQ_HZ = 25000000;
	localparam int unsigned CONV_TIME_NS = 5000;
	localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
	localparam int unsigned FIFO_DEPTH = 256;
	localparam int unsigned FIFO_AW = 8;
	localparam int unsigned SAMPLE_W = 12;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned STAT_HAS_DATA_BIT = 13;
	localparam int unsigned STAT_OVERRUN_N_BIT = 12;
	localparam int unsigned STAT_OVERFLOW_N_BIT = 11;
	localparam int unsigned STAT_ACQ_DONE_BIT = 10;
	localparam int unsigned STAT_BUSY_BIT = 9;
	localparam int unsigned CHAN_MSB = 7;
	localparam int unsigned CHAN_LSB = 4;
	localparam int unsigned GAIN_MSB = 3;
	localparam int unsigned GAIN_LSB = 1;
	localparam int unsigned CG_DEPTH = 16;
	localparam int unsigned CG_AW = 4;
	localparam logic [SAMPLE_W-1:0] SIGN_FLIP = 12'h800;
endpackage : adcfc_pkg
`default_nettype wire

// ===== core/adcfc_skid.sv
// two-entry valid/ready buffer on the result path
`timescale 1ns/1ps
`default_nettype none
module adcfc_skid #(
	parameter int unsigned WIDTH = 12
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] cnt_ff;
	logic push;
	logic pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign in_ready_o = (cnt_ff != 2'h2);
	assign out_valid_o = (cnt_ff != 2'h0);
	assign out_data_o = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || flush_i) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			cnt_ff <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
		end
	end
endmodule : adcfc_skid
`default_nettype wire

// ===== core/adcfc_top.sv
// converter start, conversion timing, result fifo and status flags
// Contract
// [R1] a host write of zero to the soft convert strobe starts exactly one conversion.
// [R2] an active-low pulse on ext_convert_n starts one conversion as the alternative start.
// [R3] each finished conversion is pushed into the result fifo without host action.
// [R4] status bit 13 is set while the fifo holds a result and clear when it is empty.
// [R5] a fifo data read pops the oldest result and has-data drops when the fifo empties.
// [R6] software reads the fifo only while has-data is set, since an empty read is meaningless.
// [R7] has-data becomes set about five microseconds after a conversion is started.
// [R8] storing more than 256 results before a read drives the active-low overflow flag low.
// [R9] a start during a conversion in progress drives the active-low overrun flag low.
// [R10] the converter clear strobe restores both error flags, clears pending requests, the fifo and acq-complete; only flag events in the same cycle win.
// [R11] with unipolar_select set, results are straight binary 0 to 4095.
// [R12] with unipolar_select clear, results are two's complement -2048 to +2047 sign-extended.
// [R13] software selects channel bits 7:4 and gain bits 3:1 by an entry write then a load write.
// [R14] software clears the channel/gain memory before loading entries.
// [R15] zeroed command registers and the clear writes leave dma, interrupts, dither, calibration off and fifo empty.
// [R16] software empties the fifo before starting conversions.
// [R17] the external pulse is synchronised and its falling edge gives one single-cycle start.
`timescale 1ns/1ps
`default_nettype none
module adcfc_top
	import adcfc_pkg::*;
#(
	parameter int unsigned DEPTH = FIFO_DEPTH,
	parameter int unsigned CONV_CNT = CONV_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic soft_convert_strobe_i,
	input wire logic [WORD_W-1:0] soft_convert_data_i,
	input wire logic ext_convert_n_i,
	input wire logic converter_clear_strobe_i,
	input wire logic unipolar_select_i,
	input wire logic cmd1_write_i,
	input wire logic cmd2_write_i,
	input wire logic [WORD_W-1:0] cmd_data_i,
	input wire logic chan_gain_clear_i,
	input wire logic chan_gain_entry_i,
	input wire logic [7:0] chan_gain_data_i,
	input wire logic chan_gain_load_i,
	input wire logic fifo_read_i,
	input wire logic [SAMPLE_W-1:0] adc_sample_i,
	output logic [WORD_W-1:0] fifo_data_o,
	output logic [WORD_W-1:0] status_o,
	output logic fifo_has_data_o,
	output logic convert_start_o,
	output logic [3:0] chan_sel_o,
	output logic [2:0] gain_sel_o,
	output logic dma_enable_o,
	output logic irq_enable_o,
	output logic dither_enable_o,
	output logic calib_enable_o,
	output logic acq_complete_flag_o
);
	typedef enum logic [0:0] {ADCFC_IDLE, ADCFC_CONV} adcfc_state_t;

	localparam int unsigned CNT_W = $clog2(CONV_CNT + 1);
	localparam int unsigned CNT_AW = $clog2(DEPTH + 1);
	localparam int unsigned PTR_W = $clog2(DEPTH);

	adcfc_state_t state_ff;
	logic [CNT_W-1:0] conv_cnt_ff;
	logic ext_meta_ff, ext_sync_ff, ext_prev_ff;
	logic ext_fall;
	logic soft_start;
	logic start;
	logic conv_done;
	logic overflow_n_ff, overrun_n_ff, acq_complete_ff;
	logic [SAMPLE_W-1:0] mem_ff [DEPTH];
	logic [$clog2(DEPTH)-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [CNT_AW-1:0] count_ff;
	logic buf_valid, buf_ready;
	logic [SAMPLE_W-1:0] buf_data;
	logic fifo_full, fifo_push, fifo_pop;
	logic [3:0] cg_chan_ff;
	logic [2:0] cg_gain_ff;
	logic [CG_AW-1:0] cg_wr_ff, cg_rd_ff;
	logic [6:0] cg_mem_ff [CG_DEPTH];

	// ext pin: two flops before any logic looks at it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ext_meta_ff <= 1'b1;
			ext_sync_ff <= 1'b1;
			ext_prev_ff <= 1'b1;
		end else begin
			ext_meta_ff <= ext_convert_n_i;
			ext_sync_ff <= ext_meta_ff;
			ext_prev_ff <= ext_sync_ff;
		end
	end
	assign ext_fall = ext_prev_ff && !ext_sync_ff; // [R17] [R2]
	assign soft_start = soft_convert_strobe_i && (soft_convert_data_i == '0); // [R1]
	assign start = (soft_start || ext_fall) && !converter_clear_strobe_i;

	// conversion timer; a start while busy is refused and flagged
	always_ff @(posedge clk_i) begin
		if (reset_i || converter_clear_strobe_i) begin
			state_ff <= ADCFC_IDLE;
			conv_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				ADCFC_IDLE: begin
					if (start) begin // [R1] [R2]
						state_ff <= ADCFC_CONV;
						conv_cnt_ff <= CNT_W'(CONV_CNT - 1);
					end
				end
				ADCFC_CONV: begin
					if (conv_done) begin
						state_ff <= ADCFC_IDLE;
					end else begin
						conv_cnt_ff <= conv_cnt_ff - CNT_W'(1); // [R7]
					end
				end
			endcase
		end
	end
	// at zero with the buffer not ready the timer wraps and counts down again, so the result waits for a later zero
	assign conv_done = (state_ff == ADCFC_CONV) && (conv_cnt_ff == '0) && buf_ready;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			convert_start_o <= 1'b0;
		end else begin
			convert_start_o <= start && (state_ff == ADCFC_IDLE);
		end
	end

	adcfc_skid #(.WIDTH(SAMPLE_W)) u_skid (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.flush_i(converter_clear_strobe_i),
		.in_valid_i(conv_done),
		.in_ready_o(buf_ready),
		.in_data_i(unipolar_select_i ? adc_sample_i : (adc_sample_i ^ SIGN_FLIP)), // [R11] [R12]
		.out_valid_o(buf_valid),
		.out_ready_i(1'b1),
		.out_data_o(buf_data)
	);

	// a word arriving at a full fifo is dropped and flagged on the active-low overflow flag
	assign fifo_full = (count_ff == CNT_AW'(DEPTH));
	assign fifo_push = buf_valid && !fifo_full; // [R3]
	assign fifo_pop = fifo_read_i && (count_ff != '0); // [R5]

	always_ff @(posedge clk_i) begin
		if (fifo_push) begin
			mem_ff[wr_ptr_ff] <= buf_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || converter_clear_strobe_i) begin // [R10]
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (fifo_push) begin
				wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
			end
			if (fifo_pop) begin
				rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
			end
			count_ff <= CNT_AW'(count_ff + {{(CNT_AW-1){1'b0}}, fifo_push} - {{(CNT_AW-1){1'b0}}, fifo_pop});
		end
	end

	// read data registered on every read strobe, even with the fifo empty; sign-extended in two's complement mode
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fifo_data_o <= '0;
		end else if (fifo_read_i) begin
			if (unipolar_select_i) begin
				fifo_data_o <= {{(WORD_W-SAMPLE_W){1'b0}}, mem_ff[rd_ptr_ff]}; // [R11]
			end else begin
				fifo_data_o <= {{(WORD_W-SAMPLE_W){mem_ff[rd_ptr_ff][SAMPLE_W-1]}}, mem_ff[rd_ptr_ff]}; // [R12]
			end
		end
	end

	// error flags: events win over the clear strobe
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			overflow_n_ff <= 1'b1;
			overrun_n_ff <= 1'b1;
			acq_complete_ff <= 1'b0;
		end else begin
			if (buf_valid && fifo_full) begin
				overflow_n_ff <= 1'b0; // [R8]
			end else if (converter_clear_strobe_i) begin
				overflow_n_ff <= 1'b1; // [R10]
			end
			if ((soft_start || ext_fall) && (state_ff == ADCFC_CONV)) begin
				overrun_n_ff <= 1'b0; // [R9]
			end else if (converter_clear_strobe_i) begin
				overrun_n_ff <= 1'b1; // [R10]
			end
			if (conv_done) begin
				acq_complete_ff <= 1'b1;
			end else if (converter_clear_strobe_i) begin
				acq_complete_ff <= 1'b0; // [R10]
			end
		end
	end

	// status is registered from the current occupancy, like fifo_has_data_o, so the two agree
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status_o <= {2'h0, 1'b0, 1'b1, 1'b1, 11'h000};
			fifo_has_data_o <= 1'b0;
		end else begin
			status_o <= '0;
			status_o[STAT_HAS_DATA_BIT] <= (count_ff != '0); // [R4]
			status_o[STAT_OVERRUN_N_BIT] <= overrun_n_ff;
			status_o[STAT_OVERFLOW_N_BIT] <= overflow_n_ff;
			status_o[STAT_ACQ_DONE_BIT] <= acq_complete_ff;
			status_o[STAT_BUSY_BIT] <= (state_ff == ADCFC_CONV);
			fifo_has_data_o <= (count_ff != '0); // [R4] [R5]
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			acq_complete_flag_o <= 1'b0;
		end else begin
			acq_complete_flag_o <= acq_complete_ff;
		end
	end

	// command registers: zero writes leave every feature off
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dma_enable_o <= 1'b0;
			irq_enable_o <= 1'b0;
			dither_enable_o <= 1'b0;
			calib_enable_o <= 1'b0;
		end else begin
			if (cmd1_write_i) begin
				dma_enable_o <= cmd_data_i[0]; // [R15]
				irq_enable_o <= cmd_data_i[1];
			end
			if (cmd2_write_i) begin
				dither_enable_o <= cmd_data_i[0]; // [R15]
				calib_enable_o <= cmd_data_i[1];
			end
		end
	end

	// channel/gain memory; load steps to the next entry and wraps after the last written
	always_ff @(posedge clk_i) begin
		if (chan_gain_entry_i) begin
			cg_mem_ff[cg_wr_ff] <= {chan_gain_data_i[CHAN_MSB:CHAN_LSB], chan_gain_data_i[GAIN_MSB:GAIN_LSB]}; // [R13]
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || chan_gain_clear_i) begin // [R14]
			cg_wr_ff <= '0;
			cg_rd_ff <= '0;
			cg_chan_ff <= '0;
			cg_gain_ff <= '0;
		end else begin
			if (chan_gain_entry_i) begin
				cg_wr_ff <= cg_wr_ff + CG_AW'(1);
			end
			if (chan_gain_load_i && (cg_wr_ff != '0)) begin
				cg_chan_ff <= cg_mem_ff[cg_rd_ff][6:3];
				cg_gain_ff <= cg_mem_ff[cg_rd_ff][2:0];
				cg_rd_ff <= ((cg_rd_ff + CG_AW'(1)) == cg_wr_ff) ? '0 : (cg_rd_ff + CG_AW'(1));
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			chan_sel_o <= '0;
			gain_sel_o <= '0;
		end else begin
			chan_sel_o <= cg_chan_ff;
			gain_sel_o <= cg_gain_ff;
		end
	end
endmodule : adcfc_top
`default_nettype wire

// ===== bench/adcfc_top_chk.sv
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
`default_nettype none
module adcfc_top_chk
	import adcfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic soft_convert_strobe_i,
	input wire logic [WORD_W-1:0] soft_convert_data_i,
	input wire logic converter_clear_strobe_i,
	input wire logic unipolar_select_i,
	input wire logic fifo_read_i,
	input wire logic [WORD_W-1:0] fifo_data_o,
	input wire logic [WORD_W-1:0] status_o,
	input wire logic fifo_has_data_o,
	input wire logic convert_start_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence soft_go;
		soft_convert_strobe_i && soft_convert_data_i == 16'h0000 && !converter_clear_strobe_i;
	endsequence
	sequence flags_cleared;
		status_o[STAT_OVERRUN_N_BIT] && status_o[STAT_OVERFLOW_N_BIT] && !status_o[STAT_ACQ_DONE_BIT] && !fifo_has_data_o;
	endsequence
	start_pulse_a: assert property (convert_start_o |=> !convert_start_o)
		else $error("start pulse longer than one cycle");
	// busy in the status word lags the timer by one cycle; a start just taken shows as the start pulse
	soft_start_a: assert property ((soft_go ##0 (!status_o[STAT_BUSY_BIT] && !convert_start_o))
		|=> convert_start_o)
		else $error("soft start not taken");
	// a conversion that ended a cycle ago still shows busy, and then the start is taken instead
	overrun_flag_a: assert property ((soft_go ##0 status_o[STAT_BUSY_BIT])
		|=> (convert_start_o or (##1 !status_o[STAT_OVERRUN_N_BIT])))
		else $error("overrun not flagged");
	has_data_bit_a: assert property (fifo_has_data_o == status_o[STAT_HAS_DATA_BIT])
		else $error("has data pin and status bit differ");
	// a clear cancels the conversion, so it ends the wait as well
	result_ready_a: assert property ((convert_start_o && !fifo_has_data_o)
		|-> ##[1:130] (fifo_has_data_o || converter_clear_strobe_i))
		else $error("result never reached the fifo");
	// only an idle clear: an event in the clear cycle wins over it
	clear_flags_a: assert property ((converter_clear_strobe_i && !soft_convert_strobe_i && !status_o[STAT_BUSY_BIT]
		&& !convert_start_o) |-> ##2 flags_cleared)
		else $error("clear left flags or data");
	// the status word shows a clear two cycles later, so the clear of the cycle before is excluded
	overflow_hold_a: assert property ((!status_o[STAT_OVERFLOW_N_BIT] && !$past(converter_clear_strobe_i))
		|=> !status_o[STAT_OVERFLOW_N_BIT])
		else $error("overflow flag dropped without clear");
	word_format_a: assert property (($past(fifo_read_i) && $stable(unipolar_select_i)) |->
		fifo_data_o[15:12] == (unipolar_select_i ? 4'h0 : {4{fifo_data_o[11]}}))
		else $error("read word upper bits wrong");
endmodule : adcfc_top_chk
bind adcfc_top adcfc_top_chk chk (.clk_i, .reset_i, .soft_convert_strobe_i, .soft_convert_data_i,
	.converter_clear_strobe_i, .unipolar_select_i, .fifo_read_i, .fifo_data_o, .status_o, .fifo_has_data_o,
	.convert_start_o);
`default_nettype wire

// ===== bench/adcfc_src.sv
// converter front end model: one fresh sample per start, and the external start pin
`timescale 1ns/1ps
`default_nettype none
module adcfc_src (
	input wire logic clk_i,
	input wire logic start_i,
	output logic [11:0] sample_o,
	output logic ext_n_o
);
	initial begin
		sample_o = 12'h7f0;
		ext_n_o = 1'b1;
	end
	// a new value per conversion makes a stale or skipped sample visible
	always @(posedge clk_i) if (start_i) sample_o <= sample_o + 12'h123;
	task automatic pulse();
		@(negedge clk_i) ext_n_o = 1'b0;
		repeat (2) @(negedge clk_i);
		ext_n_o = 1'b1;
	endtask : pulse
endmodule : adcfc_src
`default_nettype wire

// ===== bench/adc_conversion_fifo_control_test.sv
// directed tests for the converter control and result fifo block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_fifo_control_test;
	import adcfc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, sc = 1'b0, clr = 1'b0, uni = 1'b1, c1 = 1'b0, c2 = 1'b0;
	logic cgc = 1'b0, cge = 1'b0, cgl = 1'b0, rd = 1'b0;
	logic [15:0] scd = 16'h0000, cmdd = 16'h0000, fdat, stat;
	logic [7:0] cgd = 8'h00;
	logic [11:0] smp;
	logic [3:0] chan;
	logic [2:0] gain;
	logic ext_n, has, start, dma, irq, dit, cal, acq;
	int err_total = 0, checks = 0, k;
	always #20 clk = ~clk;
	adcfc_src src (.clk_i(clk), .start_i(start), .sample_o(smp), .ext_n_o(ext_n));
	adcfc_top #(.DEPTH(4), .CONV_CNT(4)) dut (.clk_i(clk), .reset_i(rst), .soft_convert_strobe_i(sc),
		.soft_convert_data_i(scd), .ext_convert_n_i(ext_n), .converter_clear_strobe_i(clr),
		.unipolar_select_i(uni), .cmd1_write_i(c1), .cmd2_write_i(c2), .cmd_data_i(cmdd),
		.chan_gain_clear_i(cgc), .chan_gain_entry_i(cge), .chan_gain_data_i(cgd), .chan_gain_load_i(cgl),
		.fifo_read_i(rd), .adc_sample_i(smp), .fifo_data_o(fdat), .status_o(stat), .fifo_has_data_o(has),
		.convert_start_o(start), .chan_sel_o(chan), .gain_sel_o(gain), .dma_enable_o(dma),
		.irq_enable_o(irq), .dither_enable_o(dit), .calib_enable_o(cal), .acq_complete_flag_o(acq));
	task automatic test_done();
		if (err_total == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask : cyc
	// entered at a falling edge; strobes are one cycle with a gap so no signal is set twice at once
	task automatic hit(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask : hit
	task automatic wait_data();
		int t;
		for (t = 0; t < 300 && has !== 1'b1; t++) @(negedge clk);
		chk({15'h0, has}, 16'h0001);
	endtask : wait_data
	// sample of the i-th accepted start, as the front end model hands it over
	function automatic logic [15:0] exp_word(input int i, input logic u);
		logic [11:0] s;
		s = 12'h7f0 + 12'(i + 1) * 12'h123;
		if (u) return {4'h0, s};
		s = s ^ SIGN_FLIP;
		return {{4{s[11]}}, s};
	endfunction : exp_word
	task automatic rd_chk(input int i);
		hit(rd);
		chk(fdat, exp_word(i, uni));
	endtask : rd_chk
	initial begin
		cyc(12);
		rst = 1'b0;
		chk(stat, 16'h1800);
		cmdd = 16'h0003;
		hit(c1);
		hit(c2);
		chk({12'h0, dma, irq, dit, cal}, 16'h000f);
		cmdd = 16'h0000;
		hit(c1);
		hit(c2);
		hit(cgc);
		hit(clr);
		cyc(2);
		chk({12'h0, dma, irq, dit, cal}, 16'h0000);
		chk(stat, 16'h1800);
		cgd = 8'ha6;
		hit(cge);
		hit(cgl);
		cyc(2);
		chk({9'h0, chan, gain}, {9'h0, 4'ha, 3'h3});
		scd = 16'h0001;
		hit(sc);
		cyc(12);
		chk({15'h0, has}, 16'h0000);
		scd = 16'h0000;
		hit(sc);
		wait_data();
		rd_chk(0);
		chk({15'h0, acq}, 16'h0001);
		uni = 1'b0;
		hit(sc);
		wait_data();
		rd_chk(1);
		uni = 1'b1;
		src.pulse();
		wait_data();
		rd_chk(2);
		cyc(12);
		chk({15'h0, has}, 16'h0000);
		hit(sc);
		hit(sc);
		chk({15'h0, stat[STAT_OVERRUN_N_BIT]}, 16'h0000);
		wait_data();
		hit(clr);
		cyc(2);
		chk(stat, 16'h1800);
		chk({15'h0, acq}, 16'h0000);
		for (k = 0; k < 5; k++) begin
			hit(sc);
			cyc(10);
		end
		chk({14'h0, stat[STAT_OVERFLOW_N_BIT], has}, 16'h0001);
		for (k = 0; k < 4; k++) rd_chk(4 + k);
		cyc(3);
		chk({15'h0, has}, 16'h0000);
		hit(clr);
		cyc(2);
		chk(stat, 16'h1800);
		test_done();
	end
	initial begin
		#(40 * 20000);
		err_total++;
		test_done();
	end
endmodule : adc_conversion_fifo_control_test
`default_nettype wire
